// File: verilog/mpk_pkg.sv
// mpk_pkg: constants for the power key and reboot sequencer.
// assumes a single 125 MHz clock domain.
package mpk_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned KEY_MIN_MS     = 1000;
    localparam int unsigned RBT_MIN_MS     = 200;
    localparam int unsigned KEY_MIN_CYC    = KEY_MIN_MS * CLK_MHZ * 1000;
    localparam int unsigned RBT_MIN_CYC    = RBT_MIN_MS * CLK_MHZ * 1000;
    localparam int unsigned RESTART_CYC    = 16;
    localparam int unsigned CNT_W          = 28;
    // ==========================================================
    // sequencer states, gray along off->on->detach->reboot; detach->off flips two bits
    typedef enum logic [2:0] {
        MPK_OFF     = 3'h0,
        MPK_ON      = 3'h1,
        MPK_DETACH  = 3'h3,
        MPK_REBOOT  = 3'h2
    } mpk_state_t;
endpackage

// File: verilog/mpk_power_seq.sv
// mpk_power_seq: power key toggle, reboot pad, detach before shutdown.
// assumes pads are open-collector from the host; pads are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module mpk_power_seq #(
    parameter int unsigned KEY_MIN_CYC = mpk_pkg::KEY_MIN_CYC,
    parameter int unsigned RBT_MIN_CYC = mpk_pkg::RBT_MIN_CYC
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // pads, low active
    input  wire logic power_key_n_i,
    output logic      power_key_n_o,
    output logic      power_key_n_oe_n,
    input  wire logic reboot_n_i,
    // software and network side
    input  wire logic sw_shutdown,
    output logic      detach_req,
    input  wire logic detach_done,
    // status
    output logic      power_indicator,
    output logic      core_rst
);
    // ==========================================================
    // pad interface
    // pad never driven: the pull-up lives in the pad cell, so the
    // enable stays released and the output holds the pulled level
    assign power_key_n_o    = 1'b1;
    assign power_key_n_oe_n = 1'b1;

    logic key_s1_ff;
    logic key_s2_ff;
    logic rbt_s1_ff;
    logic rbt_s2_ff;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            key_s1_ff <= 1'b1;
            key_s2_ff <= 1'b1;
            rbt_s1_ff <= 1'b1;
            rbt_s2_ff <= 1'b1;
        end else begin
            key_s1_ff <= power_key_n_i;
            key_s2_ff <= key_s1_ff;
            rbt_s1_ff <= reboot_n_i;
            rbt_s2_ff <= rbt_s1_ff;
        end
    end

    // ==========================================================
    // pulse width measurement
    logic [mpk_pkg::CNT_W-1:0] key_cnt_ff;
    logic [mpk_pkg::CNT_W-1:0] rbt_cnt_ff;
    logic                      key_ok_ff;
    logic                      rbt_ok_ff;
    logic                      key_rel;
    logic                      rbt_rel;

    // counters saturate so a stuck-low pad cannot wrap
    always_ff @(posedge ref_clk) begin
        if (sys_rst || key_s2_ff) begin
            key_cnt_ff <= '0;
            key_ok_ff  <= 1'b0;
        end else if (!key_ok_ff) begin
            key_cnt_ff <= key_cnt_ff + 1'b1;
            key_ok_ff  <= (key_cnt_ff == KEY_MIN_CYC[mpk_pkg::CNT_W-1:0]
                           - 1'b1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || rbt_s2_ff) begin
            rbt_cnt_ff <= '0;
            rbt_ok_ff  <= 1'b0;
        end else if (!rbt_ok_ff) begin
            rbt_cnt_ff <= rbt_cnt_ff + 1'b1;
            rbt_ok_ff  <= (rbt_cnt_ff == RBT_MIN_CYC[mpk_pkg::CNT_W-1:0]
                           - 1'b1);
        end
    end

    // action only on release of a long-enough pulse
    assign key_rel = key_ok_ff && key_s2_ff;
    assign rbt_rel = rbt_ok_ff && rbt_s2_ff;

    // ==========================================================
    // power state machine
    mpk_pkg::mpk_state_t state_ff;
    mpk_pkg::mpk_state_t nxt_state;
    logic [4:0]          rst_cnt_ff;

    always_comb begin
        nxt_state = state_ff;
        if (rbt_rel) begin
            nxt_state = mpk_pkg::MPK_REBOOT;
        end else begin
            case (state_ff)
                mpk_pkg::MPK_OFF: begin
                    if (key_rel) nxt_state = mpk_pkg::MPK_ON;
                end
                mpk_pkg::MPK_ON: begin
                    if (key_rel || sw_shutdown) begin
                        nxt_state = mpk_pkg::MPK_DETACH;
                    end
                end
                mpk_pkg::MPK_DETACH: begin
                    if (detach_done) nxt_state = mpk_pkg::MPK_OFF;
                end
                mpk_pkg::MPK_REBOOT: begin
                    if (rst_cnt_ff == 5'(mpk_pkg::RESTART_CYC - 1)) begin
                        nxt_state = mpk_pkg::MPK_ON;
                    end
                end
                default: nxt_state = mpk_pkg::MPK_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) state_ff <= mpk_pkg::MPK_OFF;
        else         state_ff <= nxt_state;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_ff != mpk_pkg::MPK_REBOOT) rst_cnt_ff <= '0;
        else rst_cnt_ff <= rst_cnt_ff + 5'h01;
    end

    // ==========================================================
    // outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            power_indicator <= 1'b0;
            detach_req      <= 1'b0;
            core_rst        <= 1'b1;
        end else begin
            power_indicator <= (nxt_state != mpk_pkg::MPK_OFF);
            detach_req      <= (nxt_state == mpk_pkg::MPK_DETACH);
            core_rst        <= (nxt_state == mpk_pkg::MPK_OFF) ||
                               (nxt_state == mpk_pkg::MPK_REBOOT);
        end
    end

    // ==========================================================
    // checks
    // release step excludes a same-cycle reboot, which wins
    sequence s_key_release;
        key_ok_ff && !key_s2_ff ##1 key_s2_ff && !rbt_rel;
    endsequence

    sequence s_detach_end;
        state_ff == mpk_pkg::MPK_DETACH && detach_done && !rbt_rel;
    endsequence

    a_no_early_off: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (state_ff == mpk_pkg::MPK_ON && !key_s2_ff && !sw_shutdown
         && !rbt_rel) |=> state_ff != mpk_pkg::MPK_DETACH)
        else $error("shutdown began while key held");
    a_detach_first: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(power_indicator) |-> $past(detach_req)
        || $past(state_ff) == mpk_pkg::MPK_OFF)
        else $error("power off without detach request");
    a_sw_detach: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (state_ff == mpk_pkg::MPK_ON && sw_shutdown && !rbt_rel)
        |=> detach_req && power_indicator)
        else $error("software shutdown gave no detach");
    // the request must stand until the network side answers
    a_detach_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (detach_req && !detach_done && !rbt_rel) |=> detach_req)
        else $error("detach request dropped early");
    a_detach_end: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        s_detach_end |=> !power_indicator && core_rst && !detach_req)
        else $error("detach end did not power off");
    a_indicator_off: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_ff == mpk_pkg::MPK_OFF |-> !power_indicator)
        else $error("indicator high while off");
    a_reset_values: assert property (
        @(posedge ref_clk)
        sys_rst |=> !power_indicator && core_rst && !detach_req)
        else $error("outputs wrong after reset");
    a_pad_released: assert property (
        @(posedge ref_clk)
        power_key_n_oe_n && power_key_n_o)
        else $error("power key pad driven");
    a_short_ignored: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (key_s2_ff && !key_ok_ff && state_ff == mpk_pkg::MPK_OFF
         && !rbt_rel) |=> state_ff == mpk_pkg::MPK_OFF)
        else $error("short key pulse acted");
    a_key_toggle: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (state_ff == mpk_pkg::MPK_OFF && !rbt_rel) ##0 s_key_release
        |-> ##1 state_ff == mpk_pkg::MPK_ON)
        else $error("qualified key did not power on");
    a_key_count: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(key_ok_ff) |-> key_cnt_ff == KEY_MIN_CYC[mpk_pkg::CNT_W-1:0])
        else $error("key qualified at wrong count");
    a_rbt_count: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(rbt_ok_ff) |-> rbt_cnt_ff == RBT_MIN_CYC[mpk_pkg::CNT_W-1:0])
        else $error("reboot qualified at wrong count");
    a_reboot_go: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rbt_rel |=> state_ff == mpk_pkg::MPK_REBOOT ##1 core_rst)
        else $error("reboot not taken");
    // restart hold is a fixed count, so the bound is generous but finite
    a_reboot_back: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(state_ff == mpk_pkg::MPK_REBOOT)
        |-> ##[1:20] power_indicator && !core_rst)
        else $error("reboot did not restart");
endmodule // mpk_power_seq
`default_nettype wire

// File: testbench/mpk_host.sv
// mpk_host: host side of the pads, open-collector pulls only.
// assumes pads idle at the internal pull-up level.
`timescale 1ns/1ps
`default_nettype none
module mpk_host (
    // clock
    input  wire logic ref_clk,
    // device pad drive
    input  wire logic key_o,
    input  wire logic key_oe_n,
    // pad levels
    output logic      key_pad,
    output logic      rbt_pad
);
    logic key_pull = 1'b0;
    logic rbt_pull = 1'b0;
    // released pad floats up, never driven high by us
    assign key_pad = key_pull ? 1'b0 : (key_oe_n ? 1'b1 : key_o);
    assign rbt_pad = ~rbt_pull;
    task automatic press(input bit rbt, input int n);
        @(posedge ref_clk);
        if (rbt) rbt_pull <= 1'b1;
        else key_pull <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rbt_pull <= 1'b0;
        key_pull <= 1'b0;
    endtask
endmodule // mpk_host
`default_nettype wire

// File: testbench/mpk_power_seq_tb.sv
// mpk_power_seq_tb: table of pad pulses, then detach and hold cases.
// assumes shortened minimum counts of 20 and 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module mpk_power_seq_tb;
    // ==========================================================
    // signals
    localparam int KEY = 20;
    localparam int RBT = 8;
    typedef struct packed {
        logic       rbt;
        logic [7:0] len;
        logic [2:0] exp;
    } mpk_row_t;
    logic      ref_clk = 1'b0;
    logic      sys_rst = 1'b1;
    logic      sw_shutdown = 1'b0;
    logic      detach_done = 1'b0;
    wire logic key_pad;
    wire logic rbt_pad;
    logic      key_o, key_oe_n, detach_req, power_indicator, core_rst;
    int        err_count = 0;
    int        samples_checked = 0;
    // {power_indicator, core_rst, detach_req}
    mpk_row_t  rows [5] = '{'{1'b0, 8'h13, 3'h2}, '{1'b0, 8'h14, 3'h4},
        '{1'b1, 8'h07, 3'h4}, '{1'b1, 8'h08, 3'h6}, '{1'b0, 8'h14, 3'h5}};
    initial forever #4 ref_clk = ~ref_clk;
    mpk_power_seq #(.KEY_MIN_CYC(KEY), .RBT_MIN_CYC(RBT)) mpk_power_seq_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .power_key_n_i(key_pad),
        .power_key_n_o(key_o), .power_key_n_oe_n(key_oe_n),
        .reboot_n_i(rbt_pad), .sw_shutdown(sw_shutdown),
        .detach_req(detach_req), .detach_done(detach_done),
        .power_indicator(power_indicator), .core_rst(core_rst));
    mpk_host mpk_host_inst (.ref_clk(ref_clk), .key_o(key_o),
        .key_oe_n(key_oe_n), .key_pad(key_pad), .rbt_pad(rbt_pad));
    // ==========================================================
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input logic [2:0] exp);
        #1;
        samples_checked++;
        if ({power_indicator, core_rst, detach_req} !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time,
                {power_indicator, core_rst, detach_req}, exp);
        end
        // back onto an edge so the next drive lands on it
        @(posedge ref_clk);
    endtask
    task automatic done_pulse;
        @(posedge ref_clk);
        detach_done <= 1'b1;
        @(posedge ref_clk);
        detach_done <= 1'b0;
        cyc(2);
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // sequence
    initial begin
        cyc(16);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk(3'h2);
        foreach (rows[i]) begin
            mpk_host_inst.press(rows[i].rbt, int'(rows[i].len));
            cyc(6);
            chk(rows[i].exp);
            cyc(30);
        end
        done_pulse();
        chk(3'h2);
        mpk_host_inst.press(1'b1, RBT);
        cyc(30);
        chk(3'h4);
        // long hold: nothing may act until release
        mpk_host_inst.key_pull <= 1'b1;
        cyc(40);
        chk(3'h4);
        mpk_host_inst.key_pull <= 1'b0;
        cyc(6);
        chk(3'h5);
        done_pulse();
        mpk_host_inst.press(1'b0, KEY);
        cyc(6);
        chk(3'h4);
        sw_shutdown <= 1'b1;
        @(posedge ref_clk);
        sw_shutdown <= 1'b0;
        cyc(2);
        chk(3'h5);
        done_pulse();
        chk(3'h2);
        // reset in mid-run while on, then power on again
        mpk_host_inst.press(1'b0, KEY);
        cyc(6);
        chk(3'h4);
        sys_rst <= 1'b1;
        cyc(3);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chk(3'h2);
        mpk_host_inst.press(1'b0, KEY);
        cyc(6);
        chk(3'h4);
        end_sim();
    end
    // tests need well under 1000 cycles
    initial begin
        cyc(5000);
        err_count++;
        end_sim();
    end
endmodule // mpk_power_seq_tb
`default_nettype wire
